// ==== hdl/ilp_checksum.sv ====
/*
  Alignment sequence checksum: modulo-256 sum of every field value.
  Combinational; fields arrive already encoded as sent on the link.
*/
`timescale 1ns/1ps
module ilp_checksum (
  input ilp_pkg::ilp_fields_t fields,
  output logic [7:0] chk
);
  import ilp_pkg::*;

  // Field values are summed, not octets, so packing bits never count
  always_comb begin
    chk = fields.did;
    chk = chk + {4'h0, fields.adjcnt} + {4'h0, fields.bid};
    chk = chk + {7'h00, fields.adjdir} + {7'h00, fields.phadj};
    chk = chk + {3'h0, fields.lid} + {7'h00, fields.scr};
    chk = chk + {3'h0, fields.l_m1} + fields.f_m1 + fields.k_m1;
    chk = chk + fields.m_m1 + {6'h00, fields.cs} + {3'h0, fields.n_m1};
    chk = chk + {5'h00, fields.subclassv} + {3'h0, fields.np_m1};
    chk = chk + {5'h00, fields.jesdv} + {3'h0, fields.s_m1};
    chk = chk + {7'h00, fields.hd} + {3'h0, fields.cf};
    chk = chk + fields.res1 + fields.res2;
  end

endmodule

// ==== hdl/ilp_link_param_gen.sv ====
/*
  Link parameter generator: builds the link configuration data sent in
  the initial lane alignment sequence and the transport format used in
  both encodings. Registers over AXI4-Lite, octets out on a
  valid/ready stream. Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module ilp_link_param_gen (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ilas_req,
  input wire logic [3:0] ilas_lane,
  output logic ilas_busy,
  output logic cfg_valid,
  output logic [7:0] cfg_octet,
  output logic [3:0] cfg_index,
  output logic cfg_last,
  input wire logic cfg_ready,
  output logic enc_64b66b,
  output ilp_pkg::ilp_tport_t tport
);
  import ilp_pkg::*;

  typedef struct packed {
    ilp_state_t state;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic scr;
    logic enc64;
    logic [4:0] mode;
    logic [7:0] did;
    logic [7:0] km1;
    logic refused;
    logic busy;
    ilp_tport_t tport;
    ilp_fields_t fields;
    logic [7:0] chk;
    logic [3:0] idx;
    logic cfg_valid;
    logic [7:0] cfg_octet;
    logic [3:0] cfg_index;
    logic cfg_last;
  } ilp_top_st_t;

  ilp_top_st_t st_ff;
  ilp_top_st_t nxt_st;
  ilp_tport_t live_tport;
  ilp_fields_t live_fields;
  logic [7:0] live_chk;
  logic [4:0] lanes;
  logic [4:0] lane_wide;
  logic lane_ok;
  logic [4:0] lane_id;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input ilp_top_st_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_SCR_BIT] = s.scr;
    w[CTRL_ENC_BIT] = s.enc64;
    w[CTRL_MODE_LSB +: 5] = s.mode;
    return w;
  endfunction

  // Octet layout of the link configuration data
  function automatic logic [7:0] octet_of(input ilp_fields_t f,
                                          input logic [7:0] chk,
                                          input logic [3:0] i);
    case (i)
      4'h0: octet_of = f.did;
      4'h1: octet_of = {f.adjcnt, f.bid};
      4'h2: octet_of = {1'b0, f.adjdir, f.phadj, f.lid};
      4'h3: octet_of = {f.scr, 2'h0, f.l_m1};
      4'h4: octet_of = f.f_m1;
      4'h5: octet_of = f.k_m1;
      4'h6: octet_of = f.m_m1;
      4'h7: octet_of = {f.cs, 1'b0, f.n_m1};
      4'h8: octet_of = {f.subclassv, f.np_m1};
      4'h9: octet_of = {f.jesdv, f.s_m1};
      4'hA: octet_of = {f.hd, 2'h0, f.cf};
      4'hB: octet_of = f.res1;
      4'hC: octet_of = f.res2;
      4'hD: octet_of = chk;
      default: octet_of = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Format follows the mode code in both encodings
  ilp_mode_table u_table (
    .link_mode_select(st_ff.mode),
    .tport(live_tport)
  );

  // Lanes 0..L-1 are the first link, L..2L-1 the second
  assign lanes = 5'(live_tport.lanes_m1 + 5'h01);
  assign lane_wide = {1'b0, ilas_lane};
  assign lane_ok = {1'b0, lane_wide} < {lanes, 1'b0};
  assign lane_id = (lane_wide >= lanes) ? 5'(lane_wide - lanes) : lane_wide;

  always_comb begin
    live_fields = '0;
    live_fields.did = st_ff.did;
    live_fields.adjcnt = 4'h0;
    live_fields.adjdir = 1'b0;
    live_fields.phadj = 1'b0;
    live_fields.bid = 4'h0;
    live_fields.cf = 5'h00;
    live_fields.lid = lane_id;
    live_fields.scr = st_ff.scr;
    live_fields.k_m1 = st_ff.km1;
    live_fields.l_m1 = live_tport.lanes_m1;
    live_fields.f_m1 = live_tport.octets_m1;
    // Converter count, not channels in use
    live_fields.m_m1 = live_tport.conv_m1;
    live_fields.n_m1 = live_tport.res_m1;
    live_fields.np_m1 = live_tport.bits_m1;
    live_fields.s_m1 = live_tport.samples_m1;
    // Real control bits and split samples still shape the transport
    live_fields.cs = 2'h0;
    live_fields.hd = 1'b0;
    live_fields.jesdv = JESDV_VAL;
    live_fields.subclassv = SUBCLASSV_VAL;
    live_fields.res1 = 8'h00;
    live_fields.res2 = 8'h00;
  end

  ilp_checksum u_chk (
    .fields(live_fields),
    .chk(live_chk)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] w;
    logic start;
    w = 32'h0000_0000;
    start = 1'b0;
    nxt_st = st_ff;
    nxt_st.tport = live_tport;

    // Write address and data are taken in either order
    if (st_ff.awready && s_axi_awvalid) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (st_ff.wready && s_axi_wvalid) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (nxt_st.aw_have && nxt_st.w_have) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      case (nxt_st.waddr)
        REG_CTRL: begin
          w = merge(ctrl_word(st_ff), nxt_st.wdata, nxt_st.wstrb);
          nxt_st.scr = w[CTRL_SCR_BIT];
          nxt_st.enc64 = w[CTRL_ENC_BIT];
          nxt_st.mode = w[CTRL_MODE_LSB +: 5];
        end
        REG_DID: begin
          w = merge({24'h000000, st_ff.did}, nxt_st.wdata, nxt_st.wstrb);
          nxt_st.did = w[7:0];
        end
        REG_KM1: begin
          w = merge({24'h000000, st_ff.km1}, nxt_st.wdata, nxt_st.wstrb);
          nxt_st.km1 = w[7:0];
        end
        REG_STAT: begin
          if (nxt_st.wstrb[0] && nxt_st.wdata[STAT_REFUSED_BIT]) begin
            nxt_st.refused = 1'b0;
          end
        end
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;

    // Read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (st_ff.arready && s_axi_arvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        REG_CTRL: nxt_st.rdata = ctrl_word(st_ff);
        REG_DID: nxt_st.rdata = {24'h000000, st_ff.did};
        REG_KM1: nxt_st.rdata = {24'h000000, st_ff.km1};
        REG_STAT: begin
          nxt_st.rdata[STAT_OK_BIT] = st_ff.tport.mode_ok;
          nxt_st.rdata[STAT_BUSY_BIT] = st_ff.busy;
          nxt_st.rdata[STAT_REFUSED_BIT] = st_ff.refused;
          nxt_st.rdata[STAT_CHK_LSB +: 8] = st_ff.chk;
        end
        default: nxt_st.rresp = RESP_SLVERR;
      endcase
    end
    nxt_st.arready = !nxt_st.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Alignment sequence: fields are frozen at start so that register
    // writes during a sequence cannot tear the octets against the checksum
    case (st_ff.state)
      ILP_IDLE: begin
        // 64B/66B sends no sequence
        if (ilas_req && !st_ff.enc64 && live_tport.mode_ok && lane_ok) begin
          start = 1'b1;
          nxt_st.state = ILP_SEND;
          nxt_st.busy = 1'b1;
          nxt_st.fields = live_fields;
          nxt_st.chk = live_chk;
          nxt_st.idx = 4'h0;
          nxt_st.cfg_valid = 1'b1;
          nxt_st.cfg_octet = octet_of(live_fields, live_chk, 4'h0);
          nxt_st.cfg_index = 4'h0;
          nxt_st.cfg_last = 1'b0;
        end
      end
      ILP_SEND: begin
        if (cfg_ready) begin
          if (st_ff.idx == ILAS_LAST_IDX) begin
            nxt_st.state = ILP_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.cfg_valid = 1'b0;
            nxt_st.cfg_last = 1'b0;
          end else begin
            nxt_st.idx = 4'(st_ff.idx + 4'h1);
            nxt_st.cfg_octet = octet_of(st_ff.fields, st_ff.chk,
                                        nxt_st.idx);
            nxt_st.cfg_index = nxt_st.idx;
            nxt_st.cfg_last = nxt_st.idx == ILAS_LAST_IDX;
          end
        end
      end
      default: begin
        nxt_st.state = ILP_IDLE;
        nxt_st.busy = 1'b0;
        nxt_st.cfg_valid = 1'b0;
      end
    endcase

    // Placed after the register write so a refusal beats a clear
    if (ilas_req && !start) begin
      nxt_st.refused = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.state <= ILP_IDLE;
      st_ff.mode <= MODE_RST;
      st_ff.did <= DID_RST;
      st_ff.km1 <= KM1_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign ilas_busy = st_ff.busy;
  assign cfg_valid = st_ff.cfg_valid;
  assign cfg_octet = st_ff.cfg_octet;
  assign cfg_index = st_ff.cfg_index;
  assign cfg_last = st_ff.cfg_last;
  assign enc_64b66b = st_ff.enc64;
  assign tport = st_ff.tport;

endmodule

// ==== hdl/ilp_mode_table.sv ====
/*
  Operating-mode lookup: turns the link mode code into the transport
  format. Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module ilp_mode_table (
  input wire logic [4:0] link_mode_select,
  output ilp_pkg::ilp_tport_t tport
);
  import ilp_pkg::*;

  function automatic ilp_tport_t entry(
    input logic [7:0] l, input logic [7:0] m, input logic [7:0] f,
    input logic [7:0] s, input logic [7:0] n, input logic [7:0] np,
    input logic [1:0] cs, input logic hd);
    ilp_tport_t t;
    t.mode_ok = 1'b1;
    t.lanes_m1 = 5'(l - 8'h01);
    t.conv_m1 = 8'(m - 8'h01);
    t.octets_m1 = 8'(f - 8'h01);
    t.samples_m1 = 5'(s - 8'h01);
    t.res_m1 = 5'(n - 8'h01);
    t.bits_m1 = 5'(np - 8'h01);
    t.cs = cs;
    t.hd = hd;
    return t;
  endfunction

  // Reserved codes give mode_ok low, which blocks any alignment sequence
  always_comb begin
    tport = '0;
    case (link_mode_select)
      5'h00, 5'h02: tport = entry(8'h04, 8'h04, 8'h08, 8'h05, 8'h0C,
                                  8'h0C, 2'h0, 1'b0);
      5'h01, 5'h03: tport = entry(8'h08, 8'h08, 8'h08, 8'h05, 8'h0C,
                                  8'h0C, 2'h0, 1'b0);
      5'h05, 5'h07: tport = entry(8'h04, 8'h01, 8'h01, 8'h04, 8'h08,
                                  8'h08, 2'h0, 1'b0);
      5'h06, 5'h08: tport = entry(8'h08, 8'h01, 8'h01, 8'h08, 8'h08,
                                  8'h08, 2'h0, 1'b0);
      5'h0A, 5'h0E: tport = entry(8'h02, 8'h02, 8'h02, 8'h01, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      5'h0B, 5'h0F: tport = entry(8'h04, 8'h02, 8'h02, 8'h02, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      5'h0C, 5'h10: tport = entry(8'h08, 8'h02, 8'h02, 8'h04, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      5'h0D: tport = entry(8'h01, 8'h02, 8'h04, 8'h01, 8'h0F, 8'h10,
                           2'h1, 1'b0);
      5'h13, 5'h14: tport = entry(8'h06, 8'h01, 8'h02, 8'h08, 8'h0C,
                                  8'h0C, 2'h0, 1'b1);
      5'h15, 5'h18: tport = entry(8'h02, 8'h01, 8'h02, 8'h02, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      5'h16, 5'h1A: tport = entry(8'h04, 8'h01, 8'h02, 8'h04, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      5'h17: tport = entry(8'h01, 8'h01, 8'h02, 8'h01, 8'h0F, 8'h10,
                           2'h1, 1'b0);
      5'h19, 5'h1B: tport = entry(8'h08, 8'h01, 8'h02, 8'h08, 8'h0F,
                                  8'h10, 2'h1, 1'b0);
      default: tport = '0;
    endcase
  end

endmodule

// ==== hdl/ilp_pkg.sv ====
/*
  Shared types and constants of the link parameter generator: register
  map, reset values, field layouts and the alignment sequence layout.
  Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
*/
package ilp_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_DID = 32'h0000_0004;
  localparam logic [31:0] REG_KM1 = 32'h0000_0008;
  localparam logic [31:0] REG_STAT = 32'h0000_000C;

  localparam int CTRL_SCR_BIT = 0;
  localparam int CTRL_ENC_BIT = 1;
  localparam int CTRL_MODE_LSB = 8;
  localparam int STAT_OK_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_CHK_LSB = 8;

  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] DID_RST = 8'h00;
  localparam logic [7:0] KM1_RST = 8'h1F;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] ILAS_LAST_IDX = 4'hD;
  localparam logic [2:0] JESDV_VAL = 3'h1;
  localparam logic [2:0] SUBCLASSV_VAL = 3'h1;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ILP_IDLE = 2'b01,
    ILP_SEND = 2'b10
  } ilp_state_t;

  // Transport format of the selected mode, counts held as value minus one
  typedef struct packed {
    logic mode_ok;
    logic [4:0] lanes_m1;
    logic [7:0] conv_m1;
    logic [7:0] octets_m1;
    logic [4:0] samples_m1;
    logic [4:0] res_m1;
    logic [4:0] bits_m1;
    logic [1:0] cs;
    logic hd;
  } ilp_tport_t;

  typedef struct packed {
    logic [7:0] did;
    logic [3:0] adjcnt;
    logic [3:0] bid;
    logic adjdir;
    logic phadj;
    logic [4:0] lid;
    logic scr;
    logic [4:0] l_m1;
    logic [7:0] f_m1;
    logic [7:0] k_m1;
    logic [7:0] m_m1;
    logic [1:0] cs;
    logic [4:0] n_m1;
    logic [2:0] subclassv;
    logic [4:0] np_m1;
    logic [2:0] jesdv;
    logic [4:0] s_m1;
    logic hd;
    logic [4:0] cf;
    logic [7:0] res1;
    logic [7:0] res2;
  } ilp_fields_t;

endpackage

// ==== verification/ilp_cfg_sink.sv ====
/*
  Link receiver model: takes configuration octets and files them by index.
  Assumes the bench selects prompt or stalling acceptance through slow.
*/
`timescale 1ns/1ps
module ilp_cfg_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic cfg_valid,
  input wire logic [7:0] cfg_octet,
  input wire logic [3:0] cfg_index,
  output logic cfg_ready,
  output logic [13:0][7:0] got,
  output logic [7:0] n_taken
);
  // Stalling every other cycle exercises the hold of each octet
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_ready <= 1'b0;
      n_taken <= 8'h00;
    end else begin
      if (cfg_valid && cfg_ready) begin
        got[cfg_index] <= cfg_octet;
        n_taken <= n_taken + 8'h01;
      end
      cfg_ready <= slow ? !cfg_ready : 1'b1;
    end
  end
endmodule

// ==== verification/ilp_link_param_gen_props.sv ====
/*
  Checker for the link parameter generator: octet stream and bus timing.
  Assumes it is bound to the generator top and sees its ports only.
*/
`timescale 1ns/1ps
module ilp_link_param_gen_props (
  input logic ref_clk,
  input logic rst_n,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic ilas_req,
  input logic [3:0] ilas_lane,
  input logic ilas_busy,
  input logic cfg_valid,
  input logic [7:0] cfg_octet,
  input logic [3:0] cfg_index,
  input logic cfg_last,
  input logic cfg_ready,
  input logic enc_64b66b,
  input ilp_pkg::ilp_tport_t tport
);
  import ilp_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_start;
    !ilas_busy && ilas_req && !enc_64b66b && tport.mode_ok &&
    ({2'b00, ilas_lane} <= {tport.lanes_m1, 1'b1})
    |=> ilas_busy && cfg_valid && cfg_index == 4'h0;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_enc;
    enc_64b66b && ilas_req && !ilas_busy |=> !ilas_busy;
  endproperty
  a_enc: assert property (p_enc) else $error("sent in 64b66b");
  property p_hold;
    cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_octet) &&
    $stable(cfg_index);
  endproperty
  a_hold: assert property (p_hold) else $error("octet dropped");
  property p_step;
    cfg_valid && cfg_ready && !cfg_last |=>
    cfg_valid && cfg_index == $past(cfg_index) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("index skipped");
  property p_last;
    cfg_valid |-> cfg_last == (cfg_index == ILAS_LAST_IDX);
  endproperty
  a_last: assert property (p_last) else $error("bad last flag");
  property p_end;
    cfg_valid && cfg_ready && cfg_last |=> !cfg_valid && !ilas_busy;
  endproperty
  a_end: assert property (p_end) else $error("sequence overran");
  property p_zero;
    cfg_valid && cfg_index == 4'h1 |-> cfg_octet == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("not zero");
  property p_hdcf;
    cfg_valid && cfg_index == 4'hA |-> cfg_octet == 8'h00;
  endproperty
  a_hdcf: assert property (p_hdcf) else $error("not zero");
  property p_res;
    cfg_valid && (cfg_index == 4'hB || cfg_index == 4'hC) |->
    cfg_octet == 8'h00;
  endproperty
  a_res: assert property (p_res) else $error("reserved set");
  property p_cs;
    cfg_valid && (cfg_index == 4'h2 || cfg_index == 4'h7) |->
    cfg_octet[7:5] == 3'h0;
  endproperty
  a_cs: assert property (p_cs) else $error("zero bits set");
  property p_ver;
    cfg_valid && (cfg_index == 4'h8 || cfg_index == 4'h9) |->
    cfg_octet[7:5] == 3'h1;
  endproperty
  a_ver: assert property (p_ver) else $error("bad version");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer lost");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer lost");
endmodule

bind ilp_link_param_gen ilp_link_param_gen_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .ilas_req(ilas_req), .ilas_lane(ilas_lane),
  .ilas_busy(ilas_busy), .cfg_valid(cfg_valid), .cfg_octet(cfg_octet),
  .cfg_index(cfg_index), .cfg_last(cfg_last), .cfg_ready(cfg_ready),
  .enc_64b66b(enc_64b66b), .tport(tport));

// ==== verification/testbench.sv ====
/*
  Bench for the link parameter generator: registers over AXI4-Lite,
  sequences collected by the receiver model. Assumes the checker is bound.
*/
`timescale 1ns/1ps
module testbench;
  import ilp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] aw_a = '0, w_d = '0, ar_a = '0, r_d, d;
  logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, req = 0, slow = 0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, busy, c_v, c_last, c_rdy, enc;
  logic [1:0] b_resp, r_resp, rs;
  logic [3:0] lane = '0, c_idx;
  logic [7:0] c_oct, n_tk, n0, did, km1, lid;
  logic [13:0][7:0] got;
  logic [7:0] e [14];
  logic scr;
  ilp_tport_t tp;
  int err_total = 0, samples_checked = 0, cyc = 0;
  // Modes 0, 10 and 19: plain, control bits in samples, high density
  logic [4:0] md [3] = '{5'h00, 5'h0A, 5'h13};
  logic [7:0] pl [3] = '{8'h04, 8'h02, 8'h06};
  logic [7:0] pm [3] = '{8'h04, 8'h02, 8'h01};
  logic [7:0] pf [3] = '{8'h08, 8'h02, 8'h02};
  logic [7:0] ps [3] = '{8'h05, 8'h01, 8'h08};
  logic [7:0] pn [3] = '{8'h0C, 8'h0F, 8'h0C};
  logic [7:0] pnp [3] = '{8'h0C, 8'h10, 8'h0C};
  logic [1:0] pcs [3] = '{2'h0, 2'h1, 2'h0};
  logic phd [3] = '{1'b0, 1'b0, 1'b1};

  ilp_link_param_gen dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .ilas_req(req),
    .ilas_lane(lane), .ilas_busy(busy), .cfg_valid(c_v),
    .cfg_octet(c_oct), .cfg_index(c_idx), .cfg_last(c_last),
    .cfg_ready(c_rdy), .enc_64b66b(enc), .tport(tp));
  ilp_cfg_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .cfg_valid(c_v), .cfg_octet(c_oct), .cfg_index(c_idx),
    .cfg_ready(c_rdy), .got(got), .n_taken(n_tk));
  ////////////////////////////////////////////////////////////////////////
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready comes a cycle after the answer, so the hold checks see a stall
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    aw_a <= a;
    aw_v <= 1'b1;
    w_d <= v;
    w_v <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
      if (b_v && !b_r) b_r <= 1'b1;
    end while (!(b_v && b_r));
    rs = b_resp;
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (ar_rdy) ar_v <= 1'b0;
      if (r_v && !r_r) r_r <= 1'b1;
    end while (!(r_v && r_r));
    d = r_d;
    rs = r_resp;
    r_r <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] ln);
    @(posedge ref_clk);
    req <= 1'b1;
    lane <= ln;
    @(posedge ref_clk);
    req <= 1'b0;
  endtask
  // Refused request: no sequence, sticky flag that write-one clears
  task automatic refused(input logic [3:0] ln);
    pulse(ln);
    repeat (3) @(posedge ref_clk);
    check(busy, 1'b0);
    rd(REG_STAT);
    check(d[2], 1'b1);
    wr(REG_STAT, 32'h0000_0004);
    rd(REG_STAT);
    check(d[2], 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(REG_CTRL);
    check(d, 32'h0);
    rd(REG_DID);
    check(d, 32'h0);
    rd(REG_KM1);
    check(d, 32'h1F);
    rd(32'h0000_0010);
    check({d, rs}, {32'h0, RESP_SLVERR});
    wr(32'h0000_0010, 32'hFFFF_FFFF);
    check(rs, RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      did = 8'h5A + 8'(i);
      km1 = 8'h1F - 8'(i);
      scr = i[0];
      slow <= i[0];
      wr(REG_DID, {24'h0, did});
      wr(REG_KM1, {24'h0, km1});
      wr(REG_CTRL, {19'h0, md[i], 7'h0, scr});
      repeat (3) @(posedge ref_clk);
      check(tp, {1'b1, 5'(pl[i] - 8'h01), pm[i] - 8'h01, pf[i] - 8'h01,
        5'(ps[i] - 8'h01), 5'(pn[i] - 8'h01), 5'(pnp[i] - 8'h01),
        pcs[i], phd[i]});
      n0 = n_tk;
      lid = 8'(i);
      pulse(4'(pl[i] + lid));
      while (n_tk !== n0 + 8'd14) @(posedge ref_clk);
      @(posedge ref_clk);
      e = '{default: 8'h00};
      e[0] = did;
      e[2] = lid;
      e[3] = {scr, 2'b00, 5'(pl[i] - 8'h01)};
      e[4] = pf[i] - 8'h01;
      e[5] = km1;
      e[6] = pm[i] - 8'h01;
      e[7] = pn[i] - 8'h01;
      e[8] = {SUBCLASSV_VAL, 5'(pnp[i] - 8'h01)};
      e[9] = {JESDV_VAL, 5'(ps[i] - 8'h01)};
      e[13] = e[0] + e[2] + 8'(scr) + 8'(e[3][4:0]) + e[4] + e[5] + e[6] +
        e[7] + 8'(SUBCLASSV_VAL) + 8'(e[8][4:0]) + 8'(JESDV_VAL) +
        8'(e[9][4:0]);
      check(got[0], e[0]);
      check(got[1], e[1]);
      check(got[2], e[2]);
      check(got[3], e[3]);
      check(got[4], e[4]);
      check(got[5], e[5]);
      check(got[6], e[6]);
      check(got[7], e[7]);
      check(got[8], e[8]);
      check(got[9], e[9]);
      check(got[10], e[10]);
      check(got[11], e[11]);
      check(got[12], e[12]);
      check(got[13], e[13]);
      rd(REG_STAT);
      check(d[15:8], e[13]);
      check(busy, 1'b0);
      $display("test mode %0d done", md[i]);
    end
    wr(REG_CTRL, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    check({enc, tp.mode_ok, tp.lanes_m1}, {2'b11, 5'h03});
    refused(4'h0);
    wr(REG_CTRL, 32'h0000_0400);
    rd(REG_STAT);
    check(d[0], 1'b0);
    refused(4'h0);
    wr(REG_CTRL, 32'h0000_0000);
    refused(4'h8);
    $display("test refusals done");
    summarize();
  end
endmodule
